// ===== dac_datapath_power_nco_control.sv
// Datapath, power protection and oscillator control registers of the dual converter
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01: Datapath bit 7 inserts the inverse sinc filter; clear bypasses it.
// R02: Bit 6 enables the oscillator mixer; bit 1 picks high (0) or low (1) image.
// R03: Bit 5 applies per-channel gain and dc offset correction.
// R04: Bit 4 applies phase correction between I and Q.
// R05: Bit 2 applies the quarter-sample-rate coarse modulation.
// R06: Bit 0 sends I samples to both outputs; Q result is discarded.
// R07: Rate code 00 gives 2x, 10 gives 4x, 11 gives 8x halfband cascade.
// R08: Thirteen-bit threshold; average power at or above it triggers protection.
// R09: Protection acts only while protection control bit 7 is set.
// R10: Protection bit 6 swaps I and Q before the power calculation.
// R11: Window code sets 512 to 2^19 pairs; host avoids codes above 1010.
// R12: Average power is readable as 13 bits over two read-only registers.
// R13: Bit 0 requests a tuning word update; bit 1 acknowledges it.
// R14: Bit 4 requests an oscillator phase reset; bit 5 acknowledges it.
// R15: Bit 6 shows a tuning word update requested by the frame signal.
// R16: Writing tuning word bytes alone never changes the active frequency.
// R17: Acknowledge rises after action, falls when request clears; host waits.
// R18: All configuration resets to zero: features off, 2x interpolation.
module dac_datapath_power_nco_control
(
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            sys_rst,
	// Serial register port
	input  wire logic [7:0]                      reg_addr,
	input  wire logic                            reg_wr,
	input  wire logic [dpctl_pkg::REG_W-1:0]     reg_wdata,
	input  wire logic                            reg_rd,
	output logic      [dpctl_pkg::REG_W-1:0]     reg_rdata,
	// Input samples
	input  wire logic                            sample_valid,
	input  wire logic [dpctl_pkg::SAMPLE_W-1:0]  sample_i,
	input  wire logic [dpctl_pkg::SAMPLE_W-1:0]  sample_q,
	// Tuning word source and frame update
	input  wire logic [dpctl_pkg::TUNE_W-1:0]    tuning_word_staged,
	input  wire logic                            frame_update,
	// Datapath feature enables
	output logic                                 sinc_comp_on,
	output logic                                 oscillator_mixer_on,
	output logic                                 image_side_select,
	output logic                                 gain_offset_correct_on,
	output logic                                 phase_correct_on,
	output logic                                 quarter_rate_mix_on,
	output logic                                 i_to_both_outputs,
	output logic                                 halfband_stage_one,
	output logic                                 halfband_stage_two,
	output logic                                 halfband_stage_three,
	// Converter sample routing
	output logic                                 converter_valid,
	output logic      [dpctl_pkg::SAMPLE_W-1:0]  in_phase_converter_data,
	output logic      [dpctl_pkg::SAMPLE_W-1:0]  quadrature_converter_data,
	// Oscillator control
	output logic      [dpctl_pkg::TUNE_W-1:0]    tuning_word_active,
	output logic                                 phase_reset_strobe,
	// Protection
	output logic                                 power_protect_trip
);
	import dpctl_pkg::*;

	// Stored configuration
	logic [REG_W-1:0]      datapath_q;
	interp_mode_t          interp_q;
	logic [REG_W-1:0]      thr_low_q;
	logic [THR_HI_W-1:0]   thr_high_q;
	logic                  prot_en_q;
	logic                  prot_swap_q;
	logic [WIN_W-1:0]      win_code_q;
	logic                  tune_req_q;
	logic                  tune_done_q;
	logic                  phase_req_q;
	logic                  phase_done_q;
	logic                  frame_flag_q;
	logic                  frame_flag_d;
	logic [TUNE_W-1:0]     tuning_word_q;
	logic                  phase_strobe_q;
	logic                  trip_q;
	logic [REG_W-1:0]      rdata_q;
	logic                  conv_valid_q;
	logic [SAMPLE_W-1:0]   conv_i_q;
	logic [SAMPLE_W-1:0]   conv_q_q;

	// Decode
	logic                  wr_datapath;
	logic                  wr_interp;
	logic                  wr_thr_low;
	logic                  wr_thr_high;
	logic                  wr_protect;
	logic                  wr_osc;
	logic                  rd_osc;
	logic                  tune_fire;
	logic                  phase_fire;
	logic                  tune_load;
	logic [WIN_W-1:0]      win_eff;
	logic [POWER_W-1:0]    threshold;
	logic [POWER_W-1:0]    power_avg;
	logic                  power_strobe;
	logic [SAMPLE_W-1:0]   power_first;
	logic [SAMPLE_W-1:0]   power_second;
	logic [REG_W-1:0]      osc_view;
	logic [REG_W-1:0]      rd_mux;

	assign wr_datapath = reg_wr && (reg_addr == OFF_DATAPATH);
	assign wr_interp   = reg_wr && (reg_addr == OFF_INTERP);
	assign wr_thr_low  = reg_wr && (reg_addr == OFF_THR_LOW);
	assign wr_thr_high = reg_wr && (reg_addr == OFF_THR_HIGH);
	assign wr_protect  = reg_wr && (reg_addr == OFF_PROTECT);
	assign wr_osc      = reg_wr && (reg_addr == OFF_OSC_CTRL);
	assign rd_osc      = reg_rd && (reg_addr == OFF_OSC_CTRL);

	// Feature enables straight from the stored control byte
	assign sinc_comp_on           = datapath_q[BIT_SINC_COMP];   // [R01]
	assign oscillator_mixer_on    = datapath_q[BIT_MIXER];       // [R02]
	assign image_side_select      = datapath_q[BIT_IMAGE_SIDE];  // [R02]
	assign gain_offset_correct_on = datapath_q[BIT_GAIN_OFFSET]; // [R03]
	assign phase_correct_on       = datapath_q[BIT_PHASE_CORR];  // [R04]
	assign quarter_rate_mix_on    = datapath_q[BIT_QUARTER_MIX]; // [R05]
	assign i_to_both_outputs      = datapath_q[BIT_I_TO_BOTH];   // [R06]

	// Reserved code 01 falls back to the 2x cascade
	assign halfband_stage_one   = 1'b1;                                        // [R07]
	assign halfband_stage_two   = (interp_q == INTERP_4X) || (interp_q == INTERP_8X); // [R07]
	assign halfband_stage_three = (interp_q == INTERP_8X);                     // [R07]

	// Illegal window codes are clamped to the longest legal window
	assign win_eff   = (win_code_q > WIN_CODE_MAX) ? WIN_CODE_MAX : win_code_q; // [R11]
	assign threshold = {thr_high_q, thr_low_q}; // [R08]

	assign power_first  = prot_swap_q ? sample_q : sample_i; // [R10]
	assign power_second = prot_swap_q ? sample_i : sample_q; // [R10]

	// Handshake: act once per request, release when the host clears it
	assign tune_fire  = tune_req_q && !tune_done_q;   // [R13]
	assign phase_fire = phase_req_q && !phase_done_q; // [R14]
	assign tune_load  = tune_fire || frame_update;    // [R16]

	// Frame flag clears on a read of the oscillator register; a new frame update wins
	assign frame_flag_d = frame_update ? 1'b1 : (rd_osc ? 1'b0 : frame_flag_q); // [R15]

	assign osc_view = {1'b0, frame_flag_q, phase_done_q, phase_req_q, 2'b00, tune_done_q, tune_req_q};

	assign rd_mux = (reg_addr == OFF_DATAPATH)   ? datapath_q :
	                (reg_addr == OFF_INTERP)     ? {6'h00, interp_q} :
	                (reg_addr == OFF_THR_LOW)    ? thr_low_q :
	                (reg_addr == OFF_THR_HIGH)   ? {3'h0, thr_high_q} :
	                (reg_addr == OFF_PROTECT)    ? {prot_en_q, prot_swap_q, 2'b00, win_code_q} :
	                (reg_addr == OFF_POWER_LOW)  ? power_avg[7:0] :              // [R12]
	                (reg_addr == OFF_POWER_HIGH) ? {3'h0, power_avg[12:8]} :     // [R12]
	                (reg_addr == OFF_OSC_CTRL)   ? osc_view :
	                RESET_BYTE;

	assign reg_rdata                 = rdata_q;
	assign tuning_word_active        = tuning_word_q;
	assign phase_reset_strobe        = phase_strobe_q;
	assign power_protect_trip        = trip_q;
	assign converter_valid           = conv_valid_q;
	assign in_phase_converter_data   = conv_i_q;
	assign quadrature_converter_data = conv_q_q;

	power_window_avg u_power (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.sample_valid  (sample_valid),
		.first_sample  (power_first),
		.second_sample (power_second),
		.window_code   (win_eff),
		.power_avg     (power_avg),
		.power_strobe  (power_strobe)
	);

	// Configuration registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			datapath_q  <= RESET_BYTE;  // [R18]
			interp_q    <= INTERP_2X;   // [R18]
			thr_low_q   <= RESET_BYTE;
			thr_high_q  <= '0;
			prot_en_q   <= 1'b0;
			prot_swap_q <= 1'b0;
			win_code_q  <= '0;
			tune_req_q  <= 1'b0;
			phase_req_q <= 1'b0;
		end else begin
			if (wr_datapath)
				datapath_q <= reg_wdata & DATAPATH_MASK;
			if (wr_interp)
				interp_q <= interp_mode_t'(reg_wdata[1:0]);
			if (wr_thr_low)
				thr_low_q <= reg_wdata;
			if (wr_thr_high)
				thr_high_q <= reg_wdata[THR_HI_W-1:0];
			if (wr_protect) begin
				prot_en_q   <= reg_wdata[BIT_PROT_ENABLE];
				prot_swap_q <= reg_wdata[BIT_PROT_SWAP];
				win_code_q  <= reg_wdata[WIN_LSB +: WIN_W];
			end
			if (wr_osc) begin
				tune_req_q  <= reg_wdata[BIT_TUNE_REQ];
				phase_req_q <= reg_wdata[BIT_PHASE_REQ];
			end
		end
	end

	// Oscillator handshakes and the active tuning word
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tune_done_q    <= 1'b0;
			phase_done_q   <= 1'b0;
			frame_flag_q   <= 1'b0;
			tuning_word_q  <= '0;
			phase_strobe_q <= 1'b0;
		end else begin
			tune_done_q    <= tune_req_q;  // [R17]
			phase_done_q   <= phase_req_q; // [R17]
			frame_flag_q   <= frame_flag_d;
			phase_strobe_q <= phase_fire;  // [R14]
			if (tune_load)
				tuning_word_q <= tuning_word_staged; // [R16]
		end
	end

	// Protection trip, read data and converter routing
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trip_q       <= 1'b0;
			rdata_q      <= RESET_BYTE;
			conv_valid_q <= 1'b0;
			conv_i_q     <= '0;
			conv_q_q     <= '0;
		end else begin
			// Level follows the latest average; dropping the enable releases it on the next clock
			trip_q       <= prot_en_q && (power_avg >= threshold); // [R09]
			conv_valid_q <= sample_valid;
			if (reg_rd)
				rdata_q <= rd_mux;
			if (sample_valid) begin
				conv_i_q <= sample_i;
				conv_q_q <= i_to_both_outputs ? sample_i : sample_q; // [R06]
			end
		end
	end

	a_sinc_follow: assert property (@(posedge clk) disable iff (sys_rst)
		wr_datapath |=> sinc_comp_on == $past(reg_wdata[BIT_SINC_COMP])) // [R01]
		else $error("sinc enable does not follow write");

	a_mixer_image_sel: assert property (@(posedge clk) disable iff (sys_rst)
		wr_datapath |=> (oscillator_mixer_on == $past(reg_wdata[BIT_MIXER]))
		&& (image_side_select == $past(reg_wdata[BIT_IMAGE_SIDE]))) // [R02]
		else $error("mixer or image select wrong");

	a_gain_offset_en: assert property (@(posedge clk) disable iff (sys_rst)
		wr_datapath |=> gain_offset_correct_on == $past(reg_wdata[BIT_GAIN_OFFSET])) // [R03]
		else $error("gain offset enable wrong");

	a_phase_corr_en: assert property (@(posedge clk) disable iff (sys_rst)
		wr_datapath |=> phase_correct_on == $past(reg_wdata[BIT_PHASE_CORR])) // [R04]
		else $error("phase correction enable wrong");

	a_quarter_mix_en: assert property (@(posedge clk) disable iff (sys_rst)
		wr_datapath |=> quarter_rate_mix_on == $past(reg_wdata[BIT_QUARTER_MIX])) // [R05]
		else $error("quarter rate enable wrong");

	a_i_both_route: assert property (@(posedge clk) disable iff (sys_rst)
		sample_valid && i_to_both_outputs |=> quadrature_converter_data == $past(sample_i)) // [R06]
		else $error("quadrature output not fed from I");

	a_interp_stages: assert property (@(posedge clk) disable iff (sys_rst)
		wr_interp && reg_wdata[1:0] == 2'b10 |=> halfband_stage_two && !halfband_stage_three) // [R07]
		else $error("4x mode stage selection wrong");

	a_trip_cause: assert property (@(posedge clk) disable iff (sys_rst)
		power_protect_trip |-> $past(prot_en_q) && ($past(power_avg) >= $past(threshold))) // [R08]
		else $error("trip without enable or over threshold");

	a_trip_disabled: assert property (@(posedge clk) disable iff (sys_rst)
		!prot_en_q ##1 !prot_en_q |-> !power_protect_trip) // [R09]
		else $error("trip while protection disabled");

	a_power_readback: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == OFF_POWER_HIGH |=> reg_rdata == {3'h0, $past(power_avg[12:8])}) // [R12]
		else $error("power high readback wrong");

	a_tune_ack: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(tune_req_q) |-> !tune_done_q ##1 tune_done_q && tuning_word_q == $past(tuning_word_staged)) // [R13]
		else $error("tuning update not acknowledged with load");

	a_phase_ack: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(phase_req_q) |=> phase_reset_strobe && phase_done_q ##1 !phase_reset_strobe) // [R14]
		else $error("phase reset handshake wrong");

	a_frame_flag: assert property (@(posedge clk) disable iff (sys_rst)
		frame_update |=> frame_flag_q) // [R15]
		else $error("frame update flag not set");

	a_word_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!$stable(tuning_word_q) |-> $past(tune_load)) // [R16]
		else $error("active tuning word changed without update");

	a_ack_release: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(tune_req_q) |-> ##1 !tune_done_q) // [R17]
		else $error("acknowledge did not release");

	a_reset_zero: assert property (@(posedge clk)
		sys_rst |=> datapath_q == RESET_BYTE && interp_q == INTERP_2X && !prot_en_q) // [R18]
		else $error("configuration not zero after reset");

	a_power_update: assert property (@(posedge clk) disable iff (sys_rst)
		!$stable(power_avg) |-> power_strobe) // [R12]
		else $error("average power changed outside a window end");
endmodule
`default_nettype wire

// ===== dac_datapath_power_nco_control_test.sv
// Self-checking bench for the datapath, protection and oscillator control registers
`timescale 1ns/1ps
`default_nettype none
module dac_datapath_power_nco_control_test;
	import dpctl_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd;
	logic        sample_valid = 1'b0;
	logic [15:0] sample_i = 16'h0000;
	logic [15:0] sample_q = 16'h0000;
	logic [31:0] tuning_word_staged = 32'h0000_0000;
	logic        frame_update = 1'b0;
	logic [9:0]  feat;
	logic        sinc_comp_on, oscillator_mixer_on, image_side_select, gain_offset_correct_on;
	logic        phase_correct_on, quarter_rate_mix_on, i_to_both_outputs;
	logic        halfband_stage_one, halfband_stage_two, halfband_stage_three;
	logic        converter_valid, phase_reset_strobe, power_protect_trip;
	logic [15:0] in_phase_converter_data, quadrature_converter_data;
	logic [31:0] tuning_word_active;
	int          n_errors = 0;
	int          n_tests = 0;
	int          seed = 31;
	int          n_strobe = 0;
	logic [7:0]  offs [8] = '{OFF_DATAPATH, OFF_INTERP, OFF_THR_LOW, OFF_THR_HIGH, OFF_PROTECT,
		OFF_POWER_LOW, OFF_POWER_HIGH, OFF_OSC_CTRL};
	logic [7:0]  masks [5] = '{8'hF7, 8'h03, 8'hFF, 8'h1F, 8'hCF};

	assign feat = {sinc_comp_on, oscillator_mixer_on, image_side_select, gain_offset_correct_on,
		phase_correct_on, quarter_rate_mix_on, i_to_both_outputs,
		halfband_stage_one, halfband_stage_two, halfband_stage_three};

	always #25 clk = ~clk;

	always @(posedge clk)
		if (phase_reset_strobe === 1'b1)
			n_strobe++;

	reg_host reg_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));

	dac_datapath_power_nco_control dac_datapath_power_nco_control_i (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_i(sample_i),
		.sample_q(sample_q), .tuning_word_staged(tuning_word_staged), .frame_update(frame_update),
		.sinc_comp_on(sinc_comp_on), .oscillator_mixer_on(oscillator_mixer_on),
		.image_side_select(image_side_select), .gain_offset_correct_on(gain_offset_correct_on),
		.phase_correct_on(phase_correct_on), .quarter_rate_mix_on(quarter_rate_mix_on),
		.i_to_both_outputs(i_to_both_outputs), .halfband_stage_one(halfband_stage_one),
		.halfband_stage_two(halfband_stage_two), .halfband_stage_three(halfband_stage_three),
		.converter_valid(converter_valid), .in_phase_converter_data(in_phase_converter_data),
		.quadrature_converter_data(quadrature_converter_data), .tuning_word_active(tuning_word_active),
		.phase_reset_strobe(phase_reset_strobe), .power_protect_trip(power_protect_trip));

	function automatic logic [12:0] exp_power(input logic signed [15:0] a, input logic signed [15:0] b);
		longint s;
		s = longint'(a) * a + longint'(b) * b;
		// Constant input, so the window mean equals one pair's power
		return 13'(s >> 19);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		results();
	end

	initial begin
		logic [7:0]  d, d2;
		logic [31:0] w;
		logic [12:0] pw;
		logic        ok;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		reg_host_i.write_reg(OFF_POWER_LOW, 8'hFF);
		reg_host_i.write_reg(OFF_POWER_HIGH, 8'hFF);
		foreach (offs[k]) begin
			reg_host_i.read_reg(offs[k], d);
			check(d, 8'h00);
		end
		reg_host_i.read_reg(8'h2E, d);
		check(d, 8'h00);
		check(feat, 10'h004);
		for (int c = 0; c < 4; c++) begin
			reg_host_i.write_reg(OFF_INTERP, 8'(c));
			check(feat[2:0], {1'b1, c[1], c[1] & c[0]});
		end
		for (int n = 0; n < 12; n++) begin
			for (int k = 0; k < 5; k++) begin
				d = 8'($random(seed));
				if (k == 4)
					d[3:0] = d[3:0] % 11;
				reg_host_i.write_reg(offs[k], d);
				reg_host_i.read_reg(offs[k], d2);
				check(d2, d & masks[k]);
				if (k == 0)
					check(feat[9:3], {d[7], d[6], d[1], d[5], d[4], d[2], d[0]});
			end
		end
		for (int n = 0; n < 40; n++) begin
			if (n % 10 == 0) begin
				d = 8'($random(seed));
				reg_host_i.write_reg(OFF_DATAPATH, d);
			end
			@(posedge clk);
			sample_valid <= 1'($random(seed));
			sample_i <= 16'($random(seed));
			sample_q <= 16'($random(seed));
			@(posedge clk);
			#1;
			check(converter_valid, sample_valid);
			if (sample_valid)
				check({in_phase_converter_data, quadrature_converter_data}, {sample_i, d[0] ? sample_i : sample_q});
		end
		@(posedge clk);
		sample_valid <= 1'b1;
		sample_i <= 16'h7000;
		sample_q <= 16'hC000;
		reg_host_i.write_reg(OFF_PROTECT, 8'h40);
		repeat (1100) @(posedge clk);
		pw = exp_power(16'h7000, 16'hC000);
		reg_host_i.read_reg(OFF_POWER_LOW, d);
		reg_host_i.read_reg(OFF_POWER_HIGH, d2);
		check({d2, d}, {3'b000, pw});
		reg_host_i.write_reg(OFF_THR_LOW, pw[7:0]);
		reg_host_i.write_reg(OFF_THR_HIGH, {3'b000, pw[12:8]});
		reg_host_i.write_reg(OFF_PROTECT, 8'hC0);
		repeat (3) @(posedge clk);
		check(power_protect_trip, 1'b1);
		reg_host_i.write_reg(OFF_THR_LOW, 8'(pw + 13'h0001));
		reg_host_i.write_reg(OFF_THR_HIGH, {3'b000, 5'((pw + 13'h0001) >> 8)});
		repeat (3) @(posedge clk);
		check(power_protect_trip, 1'b0);
		reg_host_i.write_reg(OFF_THR_LOW, pw[7:0]);
		reg_host_i.write_reg(OFF_PROTECT, 8'h40);
		repeat (3) @(posedge clk);
		check(power_protect_trip, 1'b0);
		@(posedge clk);
		w = $random(seed);
		tuning_word_staged <= w;
		reg_host_i.handshake(BIT_TUNE_REQ, 1'b1, ok);
		check(ok, 1'b1);
		check(tuning_word_active, w);
		@(posedge clk);
		tuning_word_staged <= ~w;
		repeat (4) @(posedge clk);
		check(tuning_word_active, w);
		reg_host_i.handshake(BIT_TUNE_REQ, 1'b0, ok);
		check(ok, 1'b1);
		n_strobe = 0;
		reg_host_i.handshake(BIT_PHASE_REQ, 1'b1, ok);
		check(ok, 1'b1);
		repeat (4) @(posedge clk);
		check(n_strobe, 1);
		reg_host_i.handshake(BIT_PHASE_REQ, 1'b0, ok);
		check(ok, 1'b1);
		@(posedge clk);
		w = $random(seed);
		tuning_word_staged <= w;
		frame_update <= 1'b1;
		@(posedge clk);
		frame_update <= 1'b0;
		#1;
		check(tuning_word_active, w);
		reg_host_i.read_reg(OFF_OSC_CTRL, d);
		check(d, 8'h40);
		reg_host_i.read_reg(OFF_OSC_CTRL, d);
		check(d, 8'h00);
		// Second reset in mid-run with features on and protection tripped
		reg_host_i.write_reg(OFF_DATAPATH, 8'hFF);
		reg_host_i.write_reg(OFF_PROTECT, 8'hC0);
		repeat (3) @(posedge clk);
		check(power_protect_trip, 1'b1);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		check(feat, 10'h004);
		check(power_protect_trip, 1'b0);
		check(tuning_word_active, 32'h0000_0000);
		foreach (offs[k]) begin
			reg_host_i.read_reg(offs[k], d);
			check(d, 8'h00);
		end
		results();
	end
endmodule
`default_nettype wire

// ===== dpctl_pkg.sv
// Register map, field positions and constants of the datapath control block
package dpctl_pkg;

	// Register offsets on the serial register port
	localparam logic [7:0] OFF_DATAPATH   = 8'h27;
	localparam logic [7:0] OFF_INTERP     = 8'h28;
	localparam logic [7:0] OFF_THR_LOW    = 8'h29;
	localparam logic [7:0] OFF_THR_HIGH   = 8'h2A;
	localparam logic [7:0] OFF_PROTECT    = 8'h2B;
	localparam logic [7:0] OFF_POWER_LOW  = 8'h2C;
	localparam logic [7:0] OFF_POWER_HIGH = 8'h2D;
	localparam logic [7:0] OFF_OSC_CTRL   = 8'h30;

	// Datapath feature control fields
	localparam int BIT_SINC_COMP   = 7;
	localparam int BIT_MIXER       = 6;
	localparam int BIT_GAIN_OFFSET = 5;
	localparam int BIT_PHASE_CORR  = 4;
	localparam int BIT_QUARTER_MIX = 2;
	localparam int BIT_IMAGE_SIDE  = 1;
	localparam int BIT_I_TO_BOTH   = 0;
	localparam logic [7:0] DATAPATH_MASK = 8'hF7;

	// Interpolation rate codes
	typedef enum logic [1:0] {
		INTERP_2X  = 2'b00,
		INTERP_RSV = 2'b01,
		INTERP_4X  = 2'b10,
		INTERP_8X  = 2'b11
	} interp_mode_t;

	// Protection control fields
	localparam int BIT_PROT_ENABLE = 7;
	localparam int BIT_PROT_SWAP   = 6;
	localparam int WIN_LSB         = 0;
	localparam int WIN_W           = 4;
	localparam logic [3:0] WIN_CODE_MAX = 4'hA;
	localparam int WIN_BASE_LOG2   = 9;

	// Oscillator control fields
	localparam int BIT_TUNE_REQ    = 0;
	localparam int BIT_TUNE_DONE   = 1;
	localparam int BIT_PHASE_REQ   = 4;
	localparam int BIT_PHASE_DONE  = 5;
	localparam int BIT_FRAME_FLAG  = 6;

	// Widths
	localparam int REG_W    = 8;
	localparam int THR_HI_W = 5;
	localparam int POWER_W  = 13;
	localparam int SAMPLE_W = 16;
	localparam int SQSUM_W  = 32;
	localparam int ACC_W    = 51;
	localparam int COUNT_W  = 20;
	localparam int TUNE_W   = 32;
	// Mean of the 32-bit sum is scaled to 13 bits by dropping 19 more bits
	localparam logic [5:0] POWER_SCALE_SHIFT = 6'h13;

	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;

endpackage

// ===== power_window_avg.sv
// Windowed average of I squared plus Q squared, scaled to 13 bits
`timescale 1ns/1ps
`default_nettype none
module power_window_avg
(
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            sys_rst,
	// Samples
	input  wire logic                            sample_valid,
	input  wire logic [dpctl_pkg::SAMPLE_W-1:0]  first_sample,
	input  wire logic [dpctl_pkg::SAMPLE_W-1:0]  second_sample,
	input  wire logic [dpctl_pkg::WIN_W-1:0]     window_code,
	// Result
	output logic      [dpctl_pkg::POWER_W-1:0]   power_avg,
	output logic                                 power_strobe
);
	import dpctl_pkg::*;

	logic signed [SAMPLE_W-1:0]  first_s;
	logic signed [SAMPLE_W-1:0]  second_s;
	logic signed [SQSUM_W-1:0]   first_sq;
	logic signed [SQSUM_W-1:0]   second_sq;
	logic        [SQSUM_W-1:0]   sq_sum;
	logic        [ACC_W-1:0]     acc_q;
	logic        [ACC_W-1:0]     acc_next;
	logic        [ACC_W-1:0]     acc_scaled;
	logic        [COUNT_W-1:0]   count_q;
	logic        [COUNT_W-1:0]   last_count;
	logic        [WIN_W-1:0]     code_q;
	logic        [5:0]           shift_amt;
	logic                        window_end;
	logic                        code_change;

	assign first_s     = first_sample;
	assign second_s    = second_sample;
	// Squares formed at full width; a 16-bit product would wrap
	assign first_sq    = first_s * first_s;
	assign second_sq   = second_s * second_s;
	// Each square is at most 2^30, so the sum fits 32 bits unsigned
	assign sq_sum      = unsigned'(first_sq + second_sq);
	assign acc_next    = acc_q + ACC_W'(sq_sum);
	assign last_count  = COUNT_W'((32'h1 << (WIN_BASE_LOG2 + int'(window_code))) - 32'h1); // [R11]
	assign window_end  = sample_valid && (count_q == last_count);
	assign shift_amt   = 6'(WIN_BASE_LOG2) + {2'b00, window_code} + POWER_SCALE_SHIFT;
	assign acc_scaled  = acc_next >> shift_amt;
	// A new window length restarts the window so no mixed average is reported
	assign code_change = (window_code != code_q);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			acc_q        <= '0;
			count_q      <= '0;
			code_q       <= '0;
			power_avg    <= '0;
			power_strobe <= 1'b0;
		end else begin
			code_q       <= window_code;
			power_strobe <= window_end && !code_change;
			if (code_change) begin
				acc_q   <= '0;
				count_q <= '0;
			end else if (window_end) begin
				acc_q     <= '0;
				count_q   <= '0;
				power_avg <= acc_scaled[POWER_W-1:0]; // [R08]
			end else if (sample_valid) begin
				acc_q   <= acc_next;
				count_q <= count_q + COUNT_W'(1);
			end
		end
	end

	a_window_length: assert property (@(posedge clk) disable iff (sys_rst)
		power_strobe |-> $past(count_q) == $past(last_count)) // [R11]
		else $error("window closed at wrong sample count");
endmodule
`default_nettype wire

// ===== reg_host.sv
// Serial register host model that programs the datapath control block
`timescale 1ns/1ps
`default_nettype none
module reg_host
(
	// Clock
	input  wire logic                        clk,
	// Register port
	output var  logic [7:0]                  reg_addr,
	output var  logic                        reg_wr,
	output var  logic [dpctl_pkg::REG_W-1:0] reg_wdata,
	output var  logic                        reg_rd,
	input  wire logic [dpctl_pkg::REG_W-1:0] reg_rdata
);
	import dpctl_pkg::*;

	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end

	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		// Illegal window lengths are never sent
		if (a == OFF_PROTECT && v[3:0] > WIN_CODE_MAX)
			v[3:0] = WIN_CODE_MAX;
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Idle lines show garbage rather than the last value
		reg_addr <= ~a;
		reg_wdata <= ~v;
		#1;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask

	// Sets or clears one request and polls up to eight reads for its acknowledge to follow
	task automatic handshake(input int req, input logic set, output logic ok);
		logic [7:0] r;
		ok = 1'b0;
		write_reg(OFF_OSC_CTRL, set ? (8'h01 << req) : 8'h00);
		for (int k = 0; k < 8 && !ok; k++) begin
			read_reg(OFF_OSC_CTRL, r);
			ok = (r[req+1] === set);
		end
	endtask
endmodule
`default_nettype wire
